// file: wdrc_top.v
// How it works
// R01 - watchdog counter advances only on edges of the 32.768 kHz crystal
// R02 - three-bit select picks time-out of 2^8,10,12,14,15,16,17,18 crystal periods
// R03 - key 01010B enables the watchdog, key 10101B disables it
// R04 - any other key resets device after soft delay and sets key reset flag
// R05 - power-on control value is 01010011, watchdog enabled
// R06 - key flag in bit 0, hardware sets, software clears, bits 7..4 zero
// R07 - overflow in run mode resets the device and sets time-out flag
// R08 - overflow in sleep or idle sets time-out, resets only pc and sp
// R09 - count cleared by key reset, clear instruction, halt, reset pin low
// R10 - pin config 01010101B is io, 10101010B reset input, else delayed reset
// R11 - pin config powers up as 01010101B, general io
// R12 - power-on zeroes pc and sets port data and direction high
// R13 - reset pin low resets the device; config registers keep values
// R14 - after reset release, extra delay holds the cpu before running
// R15 - software must clear the watchdog before each time-out expires
// R16 - halt sets power-down, clears time-out and count; counts only if enabled
// R17 - run-mode time-out reset acts like a pin reset plus time-out flag
// R18 - counter counts up from zero, overflows at selected tap, clears restart it
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "wdrc_defines.vh"

module wdrc_top (
   // clock and power-on reset
   input wire ref_clk_i,
   input wire reset_n_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire pready_o,
   output wire pslverr_o,
   output reg [31:0] prdata_o,
   // crystal and cpu events
   input wire lxt_clk_i,
   input wire clear_watchdog_instr_i,
   input wire halt_instr_i,
   input wire low_power_mode_i,
   // shared reset pin
   input wire ext_reset_pin_n_i,
   output reg pin_is_reset_o,
   // reset outputs
   output reg device_reset_o,
   output reg cpu_hold_o,
   output reg pc_sp_reset_o,
   // port registers
   output reg [7:0] port_data_o,
   output reg [7:0] port_dir_o,
   // interrupt
   output wire irq_o
);

   localparam [3:0] ST_RUN = 4'b0001;
   localparam [3:0] ST_SOFT = 4'b0010;
   localparam [3:0] ST_RST = 4'b0100;
   localparam [3:0] ST_HOLD = 4'b1000;
   // both delays must fit the ten-bit delay counter
   localparam integer SOFT_CYC = `WDRC_SOFT_RESET_CYC;
   localparam integer HOLD_CYC = `WDRC_RESET_DELAY_CYC;
   localparam [9:0] SOFT_LAST = SOFT_CYC[9:0] - 10'h001;
   localparam [9:0] HOLD_LAST = HOLD_CYC[9:0] - 10'h001;

   reg [7:0] wdt_ctrl_q;
   reg [7:0] pin_cfg_q;
   reg flag_key_q;
   reg flag_cfg_q;
   reg to_flag_q;
   reg pdf_flag_q;
   reg [3:0] irq_stat_q;
   reg [3:0] irq_mask_q;
   reg [17:0] cnt_q;
   reg lxt_q;
   reg lxt_prev_q;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [9:0] dly_q;
   reg cause_key_q;
   reg cause_cfg_q;

   wire [4:0] key = wdt_ctrl_q[`WDRC_KEY_MSB:`WDRC_KEY_LSB];
   wire [2:0] sel = wdt_ctrl_q[`WDRC_SEL_MSB:`WDRC_SEL_LSB];
   wire wdt_en = (key == `WDRC_KEY_ENABLE); // R03
   wire key_bad = !wdt_en && (key != `WDRC_KEY_DISABLE); // R04
   wire cfg_bad = (pin_cfg_q != `WDRC_PIN_IO) && (pin_cfg_q != `WDRC_PIN_RESET); // R10
   wire pin_rst = (pin_cfg_q == `WDRC_PIN_RESET) && !ext_reset_pin_n_i; // R13

   // apb decode
   wire setup = psel_i && !penable_i;
   wire wr = psel_i && penable_i && pwrite_i;
   wire [5:0] idx = paddr_i[7:2];
   wire mapped = (idx <= `WDRC_OFS_WDT_COUNT) && (paddr_i[1:0] == 2'b00);
   wire wr_ok = wr && mapped;
   wire wr_ctrl = wr_ok && (idx == `WDRC_OFS_WDT_CTRL);
   wire wr_pin = wr_ok && (idx == `WDRC_OFS_PIN_CFG);
   wire wr_irq = wr_ok && (idx == `WDRC_OFS_IRQ_STAT);
   wire wr_mask = wr_ok && (idx == `WDRC_OFS_IRQ_MASK);
   wire wr_pdata = wr_ok && (idx == `WDRC_OFS_PORT_DATA);
   wire wr_pdir = wr_ok && (idx == `WDRC_OFS_PORT_DIR);

   // unmapped accesses still finish at once, so a stray pointer cannot stall the bus
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;

   // crystal edge: input is already synchronous, so one stage plus history
   wire lxt_tick = lxt_q && !lxt_prev_q; // R01

   function [18:0] tap_limit;
      input [2:0] s;
      begin
         case (s)
            3'h0: tap_limit = `WDRC_TAP_SEL0;
            3'h1: tap_limit = `WDRC_TAP_SEL1;
            3'h2: tap_limit = `WDRC_TAP_SEL2;
            3'h3: tap_limit = `WDRC_TAP_SEL3;
            3'h4: tap_limit = `WDRC_TAP_SEL4;
            3'h5: tap_limit = `WDRC_TAP_SEL5;
            3'h6: tap_limit = `WDRC_TAP_SEL6;
            default: tap_limit = `WDRC_TAP_SEL7;
         endcase
      end
   endfunction

   wire [18:0] cnt_inc = {1'b0, cnt_q} + 19'h00001;
   wire ovf = lxt_tick && wdt_en && (cnt_inc == tap_limit(sel)); // R02
   wire ovf_run = ovf && !low_power_mode_i; // R07
   wire ovf_lp = ovf && low_power_mode_i; // R08
   wire in_reset = (state_q == ST_RST);
   wire soft_fire = (state_q == ST_SOFT) && (dly_q == SOFT_LAST);
   wire fire_key = soft_fire && cause_key_q;
   wire fire_cfg = soft_fire && cause_cfg_q;

   // reset sequencer
   // a pin reset pre-empts a pending soft reset; new faults are heard only in run
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (pin_rst || ovf_run)
               state_d = ST_RST; // R13 R17
            else if (key_bad || cfg_bad)
               state_d = ST_SOFT; // R04 R10
         end
         ST_SOFT: begin
            if (pin_rst || dly_q == SOFT_LAST)
               state_d = ST_RST;
         end
         ST_RST: begin
            if (!pin_rst)
               state_d = ST_HOLD;
         end
         ST_HOLD: begin
            if (pin_rst)
               state_d = ST_RST;
            else if (dly_q == HOLD_LAST)
               state_d = ST_RUN; // R14
         end
         default: state_d = ST_RUN;
      endcase
   end

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q <= ST_RUN;
         dly_q <= 10'h000;
         cause_key_q <= 1'b0;
         cause_cfg_q <= 1'b0;
         device_reset_o <= 1'b0;
         cpu_hold_o <= 1'b0;
         pc_sp_reset_o <= 1'b0;
         pin_is_reset_o <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_d != state_q)
            dly_q <= 10'h000;
         else
            dly_q <= dly_q + 10'h001;
         if (state_q == ST_RUN) begin
            cause_key_q <= key_bad;
            cause_cfg_q <= cfg_bad;
         end
         device_reset_o <= (state_d == ST_RST);
         cpu_hold_o <= (state_d == ST_RST) || (state_d == ST_HOLD); // R14
         pc_sp_reset_o <= ovf_lp; // R08
         pin_is_reset_o <= (pin_cfg_q == `WDRC_PIN_RESET);
      end
   end

   // watchdog counter
   // the count holds while disabled and restarts from zero after every clear
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lxt_q <= 1'b0;
         lxt_prev_q <= 1'b0;
         cnt_q <= 18'h00000;
      end else begin
         lxt_q <= lxt_clk_i;
         lxt_prev_q <= lxt_q;
         if (in_reset || pin_rst || clear_watchdog_instr_i || halt_instr_i)
            cnt_q <= 18'h00000; // R09 R16
         else if (ovf)
            cnt_q <= 18'h00000; // R18
         else if (lxt_tick && wdt_en)
            cnt_q <= cnt_inc[17:0]; // R18
      end
   end

   // control registers; they survive device resets, cleared only by power-on or by their own key or config fault
   reg [7:0] wdt_ctrl_d;
   reg [7:0] pin_cfg_d;

   // offending register is restored so the reset does not repeat forever
   always @* begin
      wdt_ctrl_d = wdt_ctrl_q;
      pin_cfg_d = pin_cfg_q;
      if (fire_key)
         wdt_ctrl_d = `WDRC_WDT_CTRL_RST; // R04
      else if (wr_ctrl)
         wdt_ctrl_d = pwdata_i[7:0]; // R03
      if (fire_cfg)
         pin_cfg_d = `WDRC_PIN_CFG_RST; // R10
      else if (wr_pin)
         pin_cfg_d = pwdata_i[7:0]; // R10
   end

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wdt_ctrl_q <= `WDRC_WDT_CTRL_RST; // R05
         pin_cfg_q <= `WDRC_PIN_CFG_RST; // R11
         irq_mask_q <= 4'h0;
      end else begin
         wdt_ctrl_q <= wdt_ctrl_d;
         pin_cfg_q <= pin_cfg_d;
         if (wr_mask)
            irq_mask_q <= pwdata_i[3:0];
      end
   end

   // ports go back to inputs on every device reset
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         port_data_o <= `WDRC_PORT_RST; // R12
         port_dir_o <= `WDRC_PORT_RST; // R12
      end else if (in_reset) begin
         port_data_o <= `WDRC_PORT_RST; // R13
         port_dir_o <= `WDRC_PORT_RST;
      end else begin
         if (wr_pdata)
            port_data_o <= pwdata_i[7:0];
         if (wr_pdir)
            port_dir_o <= pwdata_i[7:0];
      end
   end

   // flags: hardware set wins over a software clear in the same cycle
   wire flag_wr = wr_ok && (idx == `WDRC_OFS_RST_FLAG);
   reg flag_key_d;
   reg flag_cfg_d;
   reg to_flag_d;
   reg pdf_flag_d;

   // each hardware set is tested first, so it beats a clear in the same cycle
   always @* begin
      flag_key_d = flag_key_q;
      flag_cfg_d = flag_cfg_q;
      to_flag_d = to_flag_q;
      pdf_flag_d = pdf_flag_q;
      if (fire_key)
         flag_key_d = 1'b1; // R04
      else if (flag_wr && !pwdata_i[`WDRC_FLAG_KEY_BIT])
         flag_key_d = 1'b0; // R06
      if (fire_cfg)
         flag_cfg_d = 1'b1; // R10
      else if (flag_wr && !pwdata_i[`WDRC_FLAG_CFG_BIT])
         flag_cfg_d = 1'b0;
      if (ovf)
         to_flag_d = 1'b1; // R07 R08 R17
      else if (halt_instr_i)
         to_flag_d = 1'b0; // R16
      if (halt_instr_i)
         pdf_flag_d = 1'b1; // R16
      else if (clear_watchdog_instr_i)
         pdf_flag_d = 1'b0;
   end

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         flag_key_q <= 1'b0;
         flag_cfg_q <= 1'b0;
         to_flag_q <= 1'b0;
         pdf_flag_q <= 1'b0;
      end else begin
         flag_key_q <= flag_key_d;
         flag_cfg_q <= flag_cfg_d;
         to_flag_q <= to_flag_d;
         pdf_flag_q <= pdf_flag_d;
      end
   end

   // interrupt status, write one to clear
   // pin event is taken only on entry, not for every cycle the pin stays low
   wire [3:0] irq_ev = {pin_rst && state_q != ST_RST, ovf, fire_cfg, fire_key};
   wire [3:0] irq_clr = wr_irq ? pwdata_i[3:0] : 4'h0;
   wire [3:0] irq_stat_d = irq_ev | (irq_stat_q & ~irq_clr);

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         irq_stat_q <= 4'h0;
      else
         irq_stat_q <= irq_stat_d;
   end

   assign irq_o = |(irq_stat_q & irq_mask_q);

   // read data captured in setup, presented during access
   reg [31:0] rd_mux;

   always @* begin
      rd_mux = 32'h00000000;
      case (idx)
         `WDRC_OFS_WDT_CTRL: rd_mux = {24'h000000, wdt_ctrl_q};
         `WDRC_OFS_RST_FLAG: rd_mux = {28'h0000000, flag_cfg_q, 2'b00, flag_key_q}; // R06
         `WDRC_OFS_PIN_CFG: rd_mux = {24'h000000, pin_cfg_q};
         `WDRC_OFS_STATUS: rd_mux = {30'h00000000, pdf_flag_q, to_flag_q};
         `WDRC_OFS_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_q};
         `WDRC_OFS_IRQ_MASK: rd_mux = {28'h0000000, irq_mask_q};
         `WDRC_OFS_PORT_DATA: rd_mux = {24'h000000, port_data_o};
         `WDRC_OFS_PORT_DIR: rd_mux = {24'h000000, port_dir_o};
         `WDRC_OFS_WDT_COUNT: rd_mux = {14'h0000, cnt_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         prdata_o <= 32'h00000000;
      else if (setup)
         prdata_o <= mapped ? rd_mux : 32'h00000000;
   end

endmodule // wdrc_top

// file: wdrc_defines.vh
`ifndef WDRC_DEFINES_VH
`define WDRC_DEFINES_VH

// clock and timing
`define WDRC_CLK_MHZ 250
`define WDRC_LXT_FREQ_HZ 32768
`define WDRC_SOFT_RESET_DELAY_NS 1000
`define WDRC_SOFT_RESET_CYC ((`WDRC_SOFT_RESET_DELAY_NS * `WDRC_CLK_MHZ + 999) / 1000)
`define WDRC_RESET_DELAY_NS 1000
`define WDRC_RESET_DELAY_CYC ((`WDRC_RESET_DELAY_NS * `WDRC_CLK_MHZ + 999) / 1000)

// register word offsets, compared with paddr_i[7:2]
`define WDRC_OFS_WDT_CTRL 6'h00
`define WDRC_OFS_RST_FLAG 6'h01
`define WDRC_OFS_PIN_CFG 6'h02
`define WDRC_OFS_STATUS 6'h03
`define WDRC_OFS_IRQ_STAT 6'h04
`define WDRC_OFS_IRQ_MASK 6'h05
`define WDRC_OFS_PORT_DATA 6'h06
`define WDRC_OFS_PORT_DIR 6'h07
`define WDRC_OFS_WDT_COUNT 6'h08

// watchdog control fields
`define WDRC_KEY_MSB 7
`define WDRC_KEY_LSB 3
`define WDRC_SEL_MSB 2
`define WDRC_SEL_LSB 0
`define WDRC_KEY_ENABLE 5'h0a
`define WDRC_KEY_DISABLE 5'h15
`define WDRC_WDT_CTRL_RST 8'h53

// time-out lengths in crystal periods, one per select code
`define WDRC_TAP_SEL0 19'h00100
`define WDRC_TAP_SEL1 19'h00400
`define WDRC_TAP_SEL2 19'h01000
`define WDRC_TAP_SEL3 19'h04000
`define WDRC_TAP_SEL4 19'h08000
`define WDRC_TAP_SEL5 19'h10000
`define WDRC_TAP_SEL6 19'h20000
`define WDRC_TAP_SEL7 19'h40000

// reset pin config codes
`define WDRC_PIN_IO 8'h55
`define WDRC_PIN_RESET 8'haa
`define WDRC_PIN_CFG_RST 8'h55

// reset flag bits
`define WDRC_FLAG_KEY_BIT 0
`define WDRC_FLAG_CFG_BIT 3

// status bits
`define WDRC_STAT_TO_BIT 0
`define WDRC_STAT_PDF_BIT 1

// interrupt event bits
`define WDRC_IRQ_KEY_BIT 0
`define WDRC_IRQ_CFG_BIT 1
`define WDRC_IRQ_OVF_BIT 2
`define WDRC_IRQ_PIN_BIT 3

`define WDRC_PORT_RST 8'hff

`endif

// file: wdrc_chk_assertions.sv
`timescale 1ns/1ps
module wdrc_chk (
   // clock and reset
   input wire ref_clk_i,
   input wire reset_n_i,
   // bus and pins
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire ext_reset_pin_n_i,
   // outputs watched
   input wire pin_is_reset_o,
   input wire device_reset_o,
   input wire cpu_hold_o,
   input wire pc_sp_reset_o,
   input wire [7:0] port_data_o,
   input wire [7:0] port_dir_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   wire wr = psel_i & penable_i & pwrite_i & !cpu_hold_o & !device_reset_o;
   wire bad_key = pwdata_i[7:3] != 5'h0a && pwdata_i[7:3] != 5'h15;
   wire bad_pin = pwdata_i[7:0] != 8'h55 && pwdata_i[7:0] != 8'haa;
   // the reset must wait out the whole soft delay, not fire early
   a_key_soft_delay: assert property (
      wr && paddr_i == 8'h00 && bad_key |=> !device_reset_o [*8] ##[242:246] device_reset_o)
      else $error("bad key reset timing");
   a_pin_soft_delay: assert property (
      wr && paddr_i == 8'h08 && bad_pin |=> !device_reset_o [*8] ##[242:246] device_reset_o)
      else $error("bad pin config reset timing");
   a_pin_sel_reset: assert property (
      wr && paddr_i == 8'h08 && pwdata_i[7:0] == 8'haa |-> ##[1:2] pin_is_reset_o)
      else $error("pin not switched to reset");
   a_pin_low_reset: assert property (
      pin_is_reset_o && !ext_reset_pin_n_i |-> ##[1:3] device_reset_o)
      else $error("pin low gave no reset");
   a_hold_after_rst: assert property (
      $fell(device_reset_o) |-> cpu_hold_o [*8]) else $error("cpu hold ended early");
   a_hold_with_rst: assert property (
      device_reset_o |-> ##[0:1] cpu_hold_o) else $error("no cpu hold in reset");
   a_ports_high: assert property (
      device_reset_o |-> ##[0:1] (port_data_o == 8'hff && port_dir_o == 8'hff))
      else $error("ports not high after reset");
   a_pcsp_only: assert property (
      pc_sp_reset_o |-> !device_reset_o ##1 !pc_sp_reset_o) else $error("bad pc sp reset");
   c_dev_reset: cover property ($rose(device_reset_o));
   c_pcsp: cover property (pc_sp_reset_o);
   c_pin_mode: cover property ($rose(pin_is_reset_o));
endmodule // wdrc_chk

// file: test_watchdog_and_reset_control.sv
`timescale 1ns/1ps
module test_watchdog_and_reset_control;
   reg ref_clk_i = 0;
   reg reset_n_i = 0;
   reg psel_i = 0;
   reg penable_i = 0;
   reg pwrite_i = 0;
   reg [7:0] paddr_i = 0;
   reg [31:0] pwdata_i = 0;
   reg lxt_clk_i = 0;
   reg clear_watchdog_instr_i = 0;
   reg halt_instr_i = 0;
   reg low_power_mode_i = 0;
   reg ext_reset_pin_n_i = 1;
   wire pready_o, pslverr_o, pin_is_reset_o, device_reset_o, cpu_hold_o, pc_sp_reset_o, irq_o;
   wire [31:0] prdata_o;
   wire [7:0] port_data_o, port_dir_o;
   integer num_errors = 0, tests_run = 0, cyc = 0, n, i;
   reg [31:0] rd;
   reg er;
   reg [2:0] lc = 0;
   reg lxt_run = 0;
   // rows: slverr, address, read value after power-on
   localparam logic [40:0] ROWS [11] = '{{9'h000, 32'h53}, {9'h004, 32'h0}, {9'h008, 32'h55},
      {9'h00c, 32'h0}, {9'h010, 32'h0}, {9'h014, 32'h0}, {9'h018, 32'hff}, {9'h01c, 32'hff},
      {9'h020, 32'h0}, {9'h124, 32'h0}, {9'h101, 32'h0}};
   always #2 ref_clk_i = ~ref_clk_i;
   // crystal runs far faster than real so a time-out fits the run
   always @(posedge ref_clk_i) begin
      lc <= lc + 1;
      lxt_clk_i <= lxt_run & lc[2];
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors = num_errors + 1;
         summarize;
      end
   end
   wdrc_top DUT (.ref_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .pready_o, .pslverr_o, .prdata_o, .lxt_clk_i, .clear_watchdog_instr_i, .halt_instr_i,
      .low_power_mode_i, .ext_reset_pin_n_i, .pin_is_reset_o, .device_reset_o, .cpu_hold_o,
      .pc_sp_reset_o, .port_data_o, .port_dir_o, .irq_o);
   task summarize;
      begin
         $display("errors %0d checks %0d", num_errors, tests_run);
         if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp, input string nm);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task apb(input [7:0] a, input w, input [31:0] d);
      begin
         @(posedge ref_clk_i);
         psel_i <= 1;
         penable_i <= 0;
         paddr_i <= a;
         pwrite_i <= w;
         pwdata_i <= d;
         @(posedge ref_clk_i);
         penable_i <= 1;
         @(posedge ref_clk_i);
         while (pready_o !== 1'b1) @(posedge ref_clk_i);
         rd = prdata_o;
         er = pslverr_o;
         psel_i <= 0;
         penable_i <= 0;
      end
   endtask
   task rchk(input [7:0] a, input [31:0] e);
      begin
         apb(a, 0, 0);
         chk(rd, e, "read");
      end
   endtask
   task pulse(input c);
      begin
         @(posedge ref_clk_i);
         if (c) clear_watchdog_instr_i <= 1;
         else halt_instr_i <= 1;
         @(posedge ref_clk_i);
         clear_watchdog_instr_i <= 0;
         halt_instr_i <= 0;
      end
   endtask
   task wait_rst;
      for (n = 0; device_reset_o !== 1'b1; n = n + 1) @(negedge ref_clk_i);
   endtask
   task wait_run;
      for (n = 0; cpu_hold_o !== 1'b0; n = n + 1) @(negedge ref_clk_i);
   endtask
   initial begin
      repeat (6) @(posedge ref_clk_i);
      reset_n_i <= 1;
      for (i = 0; i < 11; i = i + 1) begin
         apb(ROWS[i][39:32], 0, 0);
         chk(rd, ROWS[i][31:0], "reset value");
         chk(er, ROWS[i][40], "slverr");
         chk(pready_o, 1, "pready");
      end
      apb(8'h14, 1, 32'hf);
      apb(8'h00, 1, 32'h50);
      lxt_run <= 1;
      pulse(1);
      wait_rst;
      chk(n >= 2024 && n <= 2072, 1, "overflow time");
      wait_run;
      rchk(8'h0c, 32'h1);
      rchk(8'h00, 32'h50);
      chk(irq_o, 1, "irq");
      apb(8'h10, 1, 32'hf);
      @(negedge ref_clk_i);
      chk(irq_o, 0, "irq");
      n = 0;
      repeat (3) begin
         repeat (1500) @(negedge ref_clk_i) n = n + (device_reset_o | cpu_hold_o);
         pulse(1);
      end
      chk(n, 0, "serviced");
      apb(8'h00, 1, 32'h51);
      pulse(1);
      wait_rst;
      chk(n >= 8168 && n <= 8216, 1, "overflow time");
      wait_run;
      apb(8'h00, 1, 32'h50);
      low_power_mode_i <= 1;
      pulse(0);
      rchk(8'h0c, 32'h2);
      while (pc_sp_reset_o !== 1'b1) @(negedge ref_clk_i);
      chk(device_reset_o, 0, "device reset");
      low_power_mode_i <= 0;
      rchk(8'h0c, 32'h3);
      apb(8'h10, 1, 32'hf);
      apb(8'h00, 1, 32'ha8);
      n = 0;
      repeat (2500) @(negedge ref_clk_i) n = n + (device_reset_o | pc_sp_reset_o);
      chk(n, 0, "disabled");
      apb(8'h00, 1, 32'h0);
      wait_rst;
      chk(n >= 248 && n <= 256, 1, "key delay");
      wait_run;
      rchk(8'h04, 32'h1);
      rchk(8'h00, 32'h53);
      chk(irq_o, 1, "irq");
      apb(8'h04, 1, 32'hff);
      rchk(8'h04, 32'h1);
      apb(8'h04, 1, 32'h0);
      rchk(8'h04, 32'h0);
      apb(8'h08, 1, 32'haa);
      apb(8'h18, 1, 32'h3c);
      apb(8'h1c, 1, 32'h0f);
      chk(pin_is_reset_o, 1, "pin mode");
      ext_reset_pin_n_i <= 0;
      repeat (5) @(negedge ref_clk_i);
      chk(device_reset_o, 1, "pin reset");
      chk(port_data_o, 8'hff, "port data");
      chk(port_dir_o, 8'hff, "port dir");
      @(posedge ref_clk_i) ext_reset_pin_n_i <= 1;
      wait_run;
      chk(n >= 250 && n <= 258, 1, "hold time");
      rchk(8'h08, 32'haa);
      apb(8'h08, 1, 32'h12);
      wait_rst;
      wait_run;
      rchk(8'h04, 32'h8);
      rchk(8'h08, 32'h55);
      chk(pin_is_reset_o, 0, "pin mode");
      apb(8'h18, 1, 32'h5a);
      apb(8'h00, 1, 32'ha8);
      reset_n_i <= 0;
      repeat (6) @(posedge ref_clk_i);
      reset_n_i <= 1;
      chk(port_data_o, 8'hff, "port data");
      rchk(8'h00, 32'h53);
      rchk(8'h04, 32'h0);
      rchk(8'h08, 32'h55);
      summarize;
   end
endmodule // test_watchdog_and_reset_control
bind wdrc_top wdrc_chk u_chk (.ref_clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .pwdata_i, .ext_reset_pin_n_i, .pin_is_reset_o, .device_reset_o, .cpu_hold_o,
   .pc_sp_reset_o, .port_data_o, .port_dir_o);
